//--- hw/alse_map.svh
`ifndef ALSE_MAP_SVH
`define ALSE_MAP_SVH

// Clock rate and the blink and pulse times in their own units.
`define ALSE_CLK_HZ 10000000
`define ALSE_BLINK_HALF_MS 250
`define ALSE_PULSE_MS 1
`define ALSE_BLINK_CYC ((`ALSE_CLK_HZ / 1000) * `ALSE_BLINK_HALF_MS)
`define ALSE_PULSE_CYC ((`ALSE_CLK_HZ / 1000) * `ALSE_PULSE_MS)

// Controller register byte offsets on the Wishbone slave.
`define ALSE_OFF_CTRL 4'h0
`define ALSE_OFF_CMD 4'h4
`define ALSE_OFF_STAT 4'h8

// Control register fields.
`define ALSE_CTRL_REMOTE_ON 0
`define ALSE_CTRL_SERIAL 1
`define ALSE_CTRL_MATED 2
`define ALSE_CTRL_UNIT_LO 4
`define ALSE_CTRL_SHELF_LO 8
`define ALSE_CTRL_RESET 32'h0000_0004

// Command register fields, write one to act.
`define ALSE_CMD_CLEAR0 0
`define ALSE_CMD_CLEAR1 1

// Status register fields: fault, warn and present line levels as seen by the shelf, alerts inverted, seen flags.
`define ALSE_STAT_FAULT 0
`define ALSE_STAT_WARN 1
`define ALSE_STAT_PRESENT 2
`define ALSE_STAT_ALERT0 3
`define ALSE_STAT_ALERT1 4
`define ALSE_STAT_SEEN0 5
`define ALSE_STAT_SEEN1 6

`endif

//--- hw/alse_pkg.sv
package alse_pkg;

    // Condition class, one-hot; the encoder sets its own priority, not this order.
    typedef enum logic [8:0] {
        ALSE_OK       = 9'h001,
        ALSE_THERM_AL = 9'h002,
        ALSE_SHUTDOWN = 9'h004,
        ALSE_AC_LIMIT = 9'h008,
        ALSE_AC_ABSENT = 9'h010,
        ALSE_OVL_SLOW = 9'h020,
        ALSE_OVL_HEAVY = 9'h040,
        ALSE_NONCAT   = 9'h080,
        ALSE_STANDBY  = 9'h100
    } alse_cond_t;

endpackage : alse_pkg

//--- hw/alse_link_if.sv
`timescale 1ns/100ps
interface alse_link_if;
    // Shelf side straps and controls.
    logic remote_grounded;
    logic protocol_tied;
    logic hot_plug_interlock;
    logic [3:0] unit_address_strap;
    logic [3:0] shelf_address_strap;
    logic [1:0] fault_clear;
    logic [1:0] scl;
    logic [1:0] sda_host_out;
    logic [1:0] sda_host_oe;
    // Device side open-drain enables.
    logic [1:0] sda_dev_out;
    logic [1:0] sda_dev_oe;
    logic fault_oe;
    logic warn_oe;
    logic present_oe;
    logic [1:0] alert_oe;
    // Wire levels with the shelf pull-ups.
    logic fault_line;
    logic warn_line;
    logic present_line;
    logic [1:0] alert_line;
    logic [1:0] sda_line;

    assign fault_line = ~fault_oe;
    assign warn_line = ~warn_oe;
    assign present_line = ~present_oe;
    assign alert_line = ~alert_oe;
    assign sda_line = ~((sda_dev_oe & ~sda_dev_out)
        | (sda_host_oe & ~sda_host_out));

    modport dev (
        input remote_grounded, protocol_tied, hot_plug_interlock,
        input unit_address_strap, shelf_address_strap, fault_clear,
        input scl, sda_line,
        output sda_dev_out, sda_dev_oe, fault_oe, warn_oe, present_oe,
        output alert_oe
    );
    modport host (
        output remote_grounded, protocol_tied, hot_plug_interlock,
        output unit_address_strap, shelf_address_strap, fault_clear,
        output scl, sda_host_out, sda_host_oe,
        input sda_line, fault_line, warn_line, present_line, alert_line
    );
endinterface : alse_link_if

//--- hw/alse_device.sv
// How it works
// - Thermal alarm: greens on, red blinks, lines high.
// - Shutdown faults: output-good off, red on, lines low.
// - Fan failure stops output only with thermal event.
// - Input out of limits: input-good blinks, lines high.
// - Input absent: LEDs off, fault high, warning low.
// - Slow overload pulses warning at 1 ms steps.
// - Slow overload blinks output-good; heavy overload faults.
// - Non-catastrophic fault: all LEDs on, fault low.
// - Faults without shutdown count as non-catastrophic.
// - Bus mode: output on only with remote grounded.
// - Module-present line held low while inserted.
// - Fault line high normally, low on failure.
// - Warning line high normally, low on low output.
// - One active-low alert per bus, no pull-ups.
// - Two buses, clock in, data two-way, no pull-ups; the device holds sda_dev_oe low, so it never drives data.
// - Open strap gives bus mode, tied gives serial.
// - Interlock pin gates operation during hot plug.
// - Bus mode captures unit and shelf address straps.
// - Alert releases on clear once event has gone.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "alse_map.svh"
module alse_device #(
    parameter int unsigned BLINK_CYC = `ALSE_BLINK_CYC,
    parameter int unsigned PULSE_CYC = `ALSE_PULSE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    alse_link_if.dev link,
    input wire logic thermal_alarm_in,
    input wire logic thermal_shutdown_in,
    input wire logic fan_fail_in,
    input wire logic fan_thermal_in,
    input wire logic fuse_blown_in,
    input wire logic boost_fail_in,
    input wire logic ov_latched_in,
    input wire logic ac_limit_in,
    input wire logic ac_absent_in,
    input wire logic overload_slow_in,
    input wire logic overload_heavy_in,
    input wire logic isolation_fail_in,
    input wire logic boost_unreg_in,
    input wire logic [1:0] alert_event_in,
    output logic input_good_led_out,
    output logic output_good_led_out,
    output logic fault_led_out,
    output logic main_output_on_out,
    output logic serial_mode_out,
    output logic [3:0] unit_address_out,
    output logic [3:0] shelf_address_out
);

    alse_pkg::alse_cond_t cond_nxt;
    alse_pkg::alse_cond_t cond_r;
    logic [22:0] blink_cnt_r;
    logic blink_r;
    logic [13:0] pulse_cnt_r;
    logic pulse_r;
    logic [1:0] alert_r;
    logic noncat;
    logic standby;

    // Counts one period and says when it has run out.
    function automatic logic period_done(input logic [22:0] cnt,
                                         input int unsigned limit);
        period_done = (cnt >= 23'(limit - 1));
    endfunction : period_done

    // A fan fault on its own keeps the output up and is reported only.
    // Isolation switch and boost regulation faults join it.
    assign noncat = (fan_fail_in & ~fan_thermal_in) | isolation_fail_in
        | boost_unreg_in;
    // Remote switch only matters in bus mode; interlock always gates.
    assign standby = ~link.hot_plug_interlock
        | (~serial_mode_out & ~link.remote_grounded);

    // Priority encoder: loss of input masks all else, then input out of limits, then shutdowns.
    always_comb begin
        if (ac_absent_in) begin
            cond_nxt = alse_pkg::ALSE_AC_ABSENT;
        end else if (ac_limit_in) begin
            cond_nxt = alse_pkg::ALSE_AC_LIMIT;
        end else if (thermal_shutdown_in | fan_thermal_in | fuse_blown_in
                     | boost_fail_in | ov_latched_in) begin
            cond_nxt = alse_pkg::ALSE_SHUTDOWN;
        end else if (overload_heavy_in) begin
            cond_nxt = alse_pkg::ALSE_SHUTDOWN;
        end else if (standby) begin
            cond_nxt = alse_pkg::ALSE_STANDBY;
        end else if (overload_slow_in) begin
            cond_nxt = alse_pkg::ALSE_OVL_SLOW;
        end else if (noncat) begin
            cond_nxt = alse_pkg::ALSE_NONCAT;
        end else if (thermal_alarm_in) begin
            cond_nxt = alse_pkg::ALSE_THERM_AL;
        end else begin
            cond_nxt = alse_pkg::ALSE_OK;
        end
    end

    // Condition register; one cycle of latency keeps outputs glitch free.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cond_r <= alse_pkg::ALSE_STANDBY;
        end else begin
            cond_r <= cond_nxt;
        end
    end

    // Blink divider gives a slow toggle shared by every blinking LED.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blink_cnt_r <= 23'h000000;
            blink_r <= 1'b0;
        end else if (period_done(blink_cnt_r, BLINK_CYC)) begin
            blink_cnt_r <= 23'h000000;
            blink_r <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 23'h000001;
        end
    end

    // Warning pulse toggles every period, restarted outside slow overload.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_cnt_r <= 14'h0000;
            pulse_r <= 1'b0;
        end else if (cond_r != alse_pkg::ALSE_OVL_SLOW) begin
            pulse_cnt_r <= 14'h0000;
            pulse_r <= 1'b0;
        end else if (period_done({9'h000, pulse_cnt_r}, PULSE_CYC)) begin
            pulse_cnt_r <= 14'h0000;
            pulse_r <= ~pulse_r;
        end else begin
            pulse_cnt_r <= pulse_cnt_r + 14'h0001;
        end
    end

    // LED and open-drain line decode from the registered condition.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            input_good_led_out <= 1'b0;
            output_good_led_out <= 1'b0;
            fault_led_out <= 1'b0;
            link.fault_oe <= 1'b0;
            link.warn_oe <= 1'b1;
            main_output_on_out <= 1'b0;
        end else begin
            unique case (cond_r)
                alse_pkg::ALSE_OK: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= 1'b1;
                    fault_led_out <= 1'b0;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= 1'b0;
                    main_output_on_out <= 1'b1;
                end
                alse_pkg::ALSE_THERM_AL: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= 1'b1;
                    fault_led_out <= blink_r;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= 1'b0;
                    main_output_on_out <= 1'b1;
                end
                alse_pkg::ALSE_SHUTDOWN: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= 1'b0;
                    fault_led_out <= 1'b1;
                    link.fault_oe <= 1'b1;
                    link.warn_oe <= 1'b1;
                    main_output_on_out <= 1'b0;
                end
                alse_pkg::ALSE_AC_LIMIT: begin
                    input_good_led_out <= blink_r;
                    output_good_led_out <= 1'b0;
                    fault_led_out <= 1'b0;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= 1'b0;
                    main_output_on_out <= 1'b0;
                end
                alse_pkg::ALSE_AC_ABSENT: begin
                    // Meaningful only while back-biased by shelf partners.
                    input_good_led_out <= 1'b0;
                    output_good_led_out <= 1'b0;
                    fault_led_out <= 1'b0;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= 1'b1;
                    main_output_on_out <= 1'b0;
                end
                alse_pkg::ALSE_OVL_SLOW: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= blink_r;
                    fault_led_out <= 1'b0;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= pulse_r;
                    main_output_on_out <= 1'b1;
                end
                alse_pkg::ALSE_NONCAT: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= 1'b1;
                    fault_led_out <= 1'b1;
                    link.fault_oe <= 1'b1;
                    link.warn_oe <= 1'b0;
                    main_output_on_out <= 1'b1;
                end
                alse_pkg::ALSE_STANDBY: begin
                    input_good_led_out <= 1'b1;
                    output_good_led_out <= 1'b0;
                    fault_led_out <= 1'b0;
                    link.fault_oe <= 1'b0;
                    link.warn_oe <= 1'b1;
                    main_output_on_out <= 1'b0;
                end
            endcase
        end
    end

    // Presence is a fixed low while the module sits in the shelf.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link.present_oe <= 1'b1;
        end else begin
            link.present_oe <= 1'b1;
        end
    end

    // Straps follow the pins while unmated and freeze once the interlock
    // mates, so a live insertion cannot disturb the captured mode.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_mode_out <= 1'b0;
            unit_address_out <= 4'h0;
            shelf_address_out <= 4'h0;
        end else if (!link.hot_plug_interlock) begin
            serial_mode_out <= link.protocol_tied;
            // Addresses only mean something in bus mode.
            if (link.protocol_tied) begin
                unit_address_out <= 4'h0;
                shelf_address_out <= 4'h0;
            end else begin
                unit_address_out <= link.unit_address_strap;
                shelf_address_out <= link.shelf_address_strap;
            end
        end
    end

    // Per-bus alerts; a new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            alert_r <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (alert_event_in[b]) begin
                    alert_r[b] <= 1'b1;
                end else if (link.fault_clear[b]) begin
                    alert_r[b] <= 1'b0;
                end
            end
        end
    end

    // Alerts and data lines are pull-down only; the shelf pulls up.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link.alert_oe <= 2'h0;
            link.sda_dev_out <= 2'h0;
            link.sda_dev_oe <= 2'h0;
        end else begin
            link.alert_oe <= alert_r;
            link.sda_dev_out <= 2'h0;
            link.sda_dev_oe <= 2'h0;
        end
    end

endmodule : alse_device

//--- hw/alse_controller.sv
`timescale 1ns/100ps
`include "alse_map.svh"
module alse_controller (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    alse_link_if.host link,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);

    logic [31:0] ctrl_r;
    logic [1:0] seen_r;
    logic [1:0] alert_q_r;
    logic [31:0] stat;
    logic req;

    assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign stat = {25'h0000000, seen_r, ~link.alert_line,
        link.present_line, link.warn_line, link.fault_line};

    // Ack one cycle after the strobe, dropped the cycle after.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= req;
            if (req && !wb_we_in && wb_adr_in == `ALSE_OFF_CTRL) begin
                wb_dat_out <= ctrl_r;
            end else if (req && !wb_we_in && wb_adr_in == `ALSE_OFF_STAT) begin
                wb_dat_out <= stat;
            end else begin
                wb_dat_out <= 32'h0000_0000;
            end
        end
    end

    // Control register with byte lanes; drives the straps and switch.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= `ALSE_CTRL_RESET;
        end else if (req && wb_we_in && wb_adr_in == `ALSE_OFF_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_in[i]) begin
                    ctrl_r[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
                end
            end
        end
    end

    // A status read arms the clear; a clear before a read is dropped.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_r <= 2'h0;
            alert_q_r <= 2'h0;
            link.fault_clear <= 2'h0;
        end else begin
            alert_q_r <= ~link.alert_line;
            link.fault_clear <= 2'h0;
            for (int b = 0; b < 2; b++) begin
                if (req && wb_we_in && wb_adr_in == `ALSE_OFF_CMD
                    && wb_sel_in[0] && wb_dat_in[b] && seen_r[b]) begin
                    link.fault_clear[b] <= 1'b1;
                    seen_r[b] <= 1'b0;
                end else if (!alert_q_r[b] && !link.alert_line[b]) begin
                    seen_r[b] <= 1'b0;
                end else if (req && !wb_we_in
                             && wb_adr_in == `ALSE_OFF_STAT) begin
                    seen_r[b] <= ~link.alert_line[b];
                end
            end
        end
    end

    // Shelf-side strap and bus idle levels, all from flops.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link.remote_grounded <= 1'b0;
            link.protocol_tied <= 1'b0;
            link.hot_plug_interlock <= 1'b0;
            link.unit_address_strap <= 4'h0;
            link.shelf_address_strap <= 4'h0;
            link.scl <= 2'h3;
            link.sda_host_out <= 2'h0;
            link.sda_host_oe <= 2'h0;
        end else begin
            link.remote_grounded <= ctrl_r[`ALSE_CTRL_REMOTE_ON];
            link.protocol_tied <= ctrl_r[`ALSE_CTRL_SERIAL];
            link.hot_plug_interlock <= ctrl_r[`ALSE_CTRL_MATED];
            link.unit_address_strap <= ctrl_r[`ALSE_CTRL_UNIT_LO +: 4];
            link.shelf_address_strap <= ctrl_r[`ALSE_CTRL_SHELF_LO +: 4];
            link.scl <= 2'h3;
            link.sda_host_out <= 2'h0;
            link.sda_host_oe <= 2'h0;
        end
    end

endmodule : alse_controller

//--- verification/alse_link_checker.sv
`timescale 1ns/100ps
module alse_link_checker (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] scl,
    input wire logic [1:0] sda_dev_oe,
    input wire logic [1:0] sda_line,
    input wire logic present_oe,
    input wire logic fault_oe,
    input wire logic [1:0] alert_oe,
    input wire logic [1:0] fault_clear
);
    // One clock domain, so clock and reset are given once for all.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Presence and bus idle levels hold at every edge.
    a_present_held: assert property (present_oe)
        else $error("Module present line not held low.");
    a_sda_released: assert property (sda_dev_oe == 2'h0)
        else $error("Device drives a data line.");
    a_sda_pulled: assert property (sda_line == 2'h3)
        else $error("Idle data line not at pull-up level.");
    a_scl_idle: assert property (scl == 2'h3)
        else $error("Bus clock not idle high.");
    // An alert may only be released two edges after its clear pulse.
    a_alert0_release: assert property ($fell(alert_oe[0]) |->
        $past(fault_clear[0], 2))
        else $error("Alert 0 released without a clear.");
    a_alert1_release: assert property ($fell(alert_oe[1]) |->
        $past(fault_clear[1], 2))
        else $error("Alert 1 released without a clear.");
    // A clear is a single-cycle pulse, so one command clears once.
    a_clear0_pulse: assert property (fault_clear[0] |=>
        !fault_clear[0])
        else $error("Clear 0 pulse longer than one cycle.");
    a_clear1_pulse: assert property (fault_clear[1] |=>
        !fault_clear[1])
        else $error("Clear 1 pulse longer than one cycle.");

    // Main scenarios that the bench is expected to reach.
    c_clear0: cover property (fault_clear[0]);
    c_alert1: cover property (alert_oe[1]);
    c_fault: cover property (fault_oe);
endmodule : alse_link_checker

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int BLINK = 8;
    localparam int PULSE = 4;
    // Condition masks and expected {ig,og,fl,fault,warn}: 0, 1, 2=toggles.
    localparam logic [12:0] CMASK [13] = '{13'h0001, 13'h0002, 13'h000C,
        13'h0010, 13'h0020, 13'h0040, 13'h0400, 13'h0004, 13'h0800,
        13'h1000, 13'h0080, 13'h0100, 13'h0200};
    localparam logic [9:0] CEXP [13] = '{10'h165, 10'h110, 10'h110,
        10'h110, 10'h110, 10'h110, 10'h110, 10'h151, 10'h151, 10'h151,
        10'h205, 10'h004, 10'h186};
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [12:0] cond = 13'h0000;
    logic [1:0] alert_ev = 2'h0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_wdata = 32'h0;
    logic [31:0] wb_rdata;
    logic wb_ack;
    logic ig, og, fl, main_on, serial_mode;
    logic [3:0] unit_addr, shelf_addr;
    int tests_run = 0;
    int miscompares = 0;
    int cycles = 0;

    // Free-running 10 MHz clock.
    always #50 sys_clk_in = ~sys_clk_in;

    alse_link_if alse_link_if_i ();

    alse_device #(.BLINK_CYC(BLINK), .PULSE_CYC(PULSE)) alse_device_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(alse_link_if_i.dev),
        .thermal_alarm_in(cond[0]), .thermal_shutdown_in(cond[1]),
        .fan_fail_in(cond[2]), .fan_thermal_in(cond[3]),
        .fuse_blown_in(cond[4]), .boost_fail_in(cond[5]),
        .ov_latched_in(cond[6]), .ac_limit_in(cond[7]),
        .ac_absent_in(cond[8]), .overload_slow_in(cond[9]),
        .overload_heavy_in(cond[10]), .isolation_fail_in(cond[11]),
        .boost_unreg_in(cond[12]), .alert_event_in(alert_ev),
        .input_good_led_out(ig), .output_good_led_out(og),
        .fault_led_out(fl), .main_output_on_out(main_on),
        .serial_mode_out(serial_mode), .unit_address_out(unit_addr),
        .shelf_address_out(shelf_addr));

    alse_controller alse_controller_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .link(alse_link_if_i.host), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
        .wb_dat_in(wb_wdata), .wb_dat_out(wb_rdata), .wb_ack_out(wb_ack));

    alse_link_checker alse_link_checker_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .scl(alse_link_if_i.scl), .sda_dev_oe(alse_link_if_i.sda_dev_oe),
        .sda_line(alse_link_if_i.sda_line),
        .present_oe(alse_link_if_i.present_oe),
        .fault_oe(alse_link_if_i.fault_oe),
        .alert_oe(alse_link_if_i.alert_oe),
        .fault_clear(alse_link_if_i.fault_clear));

    task chk_bit(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
        end
    endtask : chk_bit

    task chk_word(input string name, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : chk_word

    // Classic cycle: hold the request until ack is sampled, then release.
    task wb_cycle(input logic we, input logic [3:0] adr,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdata <= wd;
        do begin
            @(posedge sys_clk_in);
        end while (wb_ack !== 1'b1);
        rd = wb_rdata;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // The slave must drop ack in the cycle after it gave it.
        @(negedge sys_clk_in);
        chk_bit("wb_ack_drop", 1'b0, wb_ack);
    endtask : wb_cycle

    task t_reset;
        logic [31:0] rd;
        wb_cycle(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        wb_cycle(1'b0, 4'h0, 32'h0, rd);
        chk_word("ctrl_reset", 32'h0000_0004, rd);
        wb_cycle(1'b0, 4'h8, 32'h0, rd);
        chk_word("stat_standby", 32'h0000_0001, rd);
        wb_cycle(1'b0, 4'hC, 32'h0, rd);
        chk_word("unmapped_read", 32'h0, rd);
        chk_bit("serial_mode", 1'b0, serial_mode);
        chk_word("addresses", 32'h0, {24'h0, unit_addr, shelf_addr});
        chk_word("standby_leds", 32'h4, {29'h0, ig, og, fl});
        chk_bit("standby_main", 1'b0, main_on);
    endtask : t_reset

    // Remote grounded but unmated stays in standby; mating then runs.
    task t_modes;
        logic [31:0] rd;
        wb_cycle(1'b1, 4'h0, 32'h0000_0A50, rd);
        repeat (4) @(negedge sys_clk_in);
        chk_word("bus_addresses", 32'h5A, {24'h0, unit_addr, shelf_addr});
        wb_cycle(1'b1, 4'h0, 32'h0000_0A52, rd);
        repeat (4) @(negedge sys_clk_in);
        chk_bit("serial_set", 1'b1, serial_mode);
        chk_word("serial_addresses", 32'h0, {24'h0, unit_addr, shelf_addr});
        wb_cycle(1'b1, 4'h0, 32'h0000_0A56, rd);
        repeat (4) @(negedge sys_clk_in);
        chk_bit("serial_main", 1'b1, main_on);
        wb_cycle(1'b1, 4'h0, 32'h0000_0001, rd);
        repeat (4) @(negedge sys_clk_in);
        chk_bit("unmated_main", 1'b0, main_on);
        chk_bit("unmated_warn", 1'b0, alse_link_if_i.warn_line);
        wb_cycle(1'b1, 4'h0, 32'h0000_0005, rd);
        repeat (4) @(negedge sys_clk_in);
        chk_word("ok_leds", 32'h6, {29'h0, ig, og, fl});
        chk_bit("ok_main", 1'b1, main_on);
        wb_cycle(1'b0, 4'h8, 32'h0, rd);
        chk_word("stat_ok", 32'h0000_0003, rd);
    endtask : t_modes

    // Each condition is held long enough to see a whole blink period.
    task t_conds;
        logic [9:0] got;
        logic [4:0] s0, s1, v;
        for (int i = 0; i < 13; i++) begin
            @(posedge sys_clk_in);
            cond <= CMASK[i];
            repeat (4) @(posedge sys_clk_in);
            s0 = 5'h00;
            s1 = 5'h00;
            repeat (40) begin
                @(negedge sys_clk_in);
                v = {ig, og, fl, alse_link_if_i.fault_line,
                    alse_link_if_i.warn_line};
                s1 = s1 | v;
                s0 = s0 | ~v;
            end
            for (int k = 0; k < 5; k++) begin
                got[2*k +: 2] = (s1[k] & s0[k]) ? 2'h2 : {1'b0, s1[k]};
            end
            chk_word("cond_outputs", 32'(CEXP[i]), 32'(got));
        end
        @(posedge sys_clk_in);
        cond <= 13'h0000;
    endtask : t_conds

    // A clear before the status read is dropped; after it, it releases.
    task t_alert;
        logic [31:0] rd;
        logic [1:0] e;
        for (int b = 0; b < 2; b++) begin
            e = ~(2'h1 << b);
            @(posedge sys_clk_in);
            alert_ev <= 2'h1 << b;
            @(posedge sys_clk_in);
            alert_ev <= 2'h0;
            repeat (4) @(negedge sys_clk_in);
            chk_word("alert_set", 32'(e), 32'(alse_link_if_i.alert_line));
            wb_cycle(1'b1, 4'h4, 32'h1 << b, rd);
            repeat (4) @(negedge sys_clk_in);
            chk_word("alert_kept", 32'(e), 32'(alse_link_if_i.alert_line));
            wb_cycle(1'b0, 4'h8, 32'h0, rd);
            chk_bit("stat_alert", 1'b1, rd[3+b]);
            wb_cycle(1'b1, 4'h4, 32'h1 << b, rd);
            repeat (4) @(negedge sys_clk_in);
            chk_word("alert_free", 32'h3, 32'(alse_link_if_i.alert_line));
        end
    endtask : t_alert

    task finish_test;
        $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // A hang is cut short and reported as a mismatch.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_modes();
        t_conds();
        t_alert();
        finish_test();
    end
endmodule : tb
